// ==== tle_line_set.sv ====
// one set of cache-line tags with hit lookup for two probe addresses
// assumes inserts arrive one per cycle from the owning unit
`timescale 1ns/1ns
`default_nettype none
module tle_line_set
   import tle_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              clear,
   input  wire logic              insert,
   input  wire logic [LINE_W-1:0] insertLine,
   input  wire logic [LINE_W-1:0] probeLine,
   input  wire logic [LINE_W-1:0] peerLine,
   output logic                   probeHit,
   output logic                   peerHit,
   output logic                   full
);
   logic [LINE_W-1:0]    tag   [SET_DEPTH];
   logic [SET_DEPTH-1:0] valid;
   logic [SET_IDX_W:0]   count;
   logic [SET_DEPTH-1:0] probeVec;
   logic [SET_DEPTH-1:0] peerVec;

   genvar g;
   generate
      for (g = 0; g < SET_DEPTH; g++) begin : gEntry
         assign probeVec[g] = valid[g] && tag[g] == probeLine;
         assign peerVec[g]  = valid[g] && tag[g] == peerLine;
         always_ff @(posedge clk) begin
            if (rst || clear) begin
               valid[g] <= 1'b0;
               tag[g]   <= '0;
            end else if (insert && !probeHit && !full && count[SET_IDX_W-1:0] == g) begin
               valid[g] <= 1'b1; // R1
               tag[g]   <= insertLine;
            end
         end
      end
   endgenerate

   assign probeHit = |probeVec;
   assign peerHit  = |peerVec;
   assign full     = count[SET_IDX_W];

   always_ff @(posedge clk) begin
      if (rst || clear) begin
         count <= '0;
      end else if (insert && !probeHit && !full) begin
         count <= count + 1'b1;
      end
   end
endmodule : tle_line_set
`default_nettype wire

// ==== tle_peer.sv ====
// peer logical processor: snoops on command and counts fabric writes
// assumes bench commands change on the falling clock edge
`timescale 1ns/1ns
`default_nettype none
module tle_peer
   import tle_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              go,
   input  wire logic              isWrite,
   input  wire logic [ADDR_W-1:0] cmdAddr,
   input  wire logic              extWriteValid,
   output logic                   peerRead,
   output logic                   peerWrite,
   output logic [ADDR_W-1:0]      peerAddr,
   output logic [7:0]             nSeen
);
   logic [ADDR_W-1:0] held;
   assign peerRead  = go & ~isWrite;
   assign peerWrite = go & isWrite;
   // between snoops the address is the inverse of the last, never a stale match
   assign peerAddr  = go ? cmdAddr : ~held;
   always_ff @(posedge clk) begin
      if (rst) held <= '0;
      else if (go) held <= cmdAddr;
   end
   // only fabric writes count, so a buffered region stays unseen
   always_ff @(posedge clk) begin
      if (rst) nSeen <= '0;
      else if (extWriteValid) nSeen <= nSeen + 8'h01;
   end
endmodule : tle_peer
`default_nettype wire

// ==== tle_pkg.sv ====
// package of constants and types for the transactional lock elision unit
// assumes one core clock domain and synchronous active-high reset
// Notes on behaviour
// R1: record read and write lines per transaction
// R2: peer read of write line, write of either conflicts
// R3: detected conflict aborts the active transaction
// R4: buffered writes released together only on commit
// R5: abort discards buffer and restarts non-transactionally
// R6: capacity overflow or disruptive event aborts
// R7: acquire hint: no lock write, lock in read set
// R8: elided lock never written externally meanwhile
// R9: own lock read returns the elided acquire value
// R10: matching release suppresses write then commits
// R11: failed hinted region reruns without elision
// R12: without elision support hints are plain prefixes
// R13: software must provide a lock-taking fallback path
// R14: query reports transactional state, explicit abort aborts
// R15: suspend and resume load tracking into read set
// R16: abort restarts at fallback with status in accumulator
// R17: explicit abort loads 8-bit code into accumulator
// R18: nesting count enters at one, commits at zero
// R19: one in-transaction flag drives query result
package tle_pkg;
   // ************************************************************
   // sizes
   // ************************************************************
   localparam int ADDR_W    = 32;
   localparam int LINE_LSB  = 6;
   localparam int LINE_W    = ADDR_W - LINE_LSB;
   localparam int DATA_W    = 32;
   localparam int SET_DEPTH = 8;
   localparam int SET_IDX_W = 3;
   localparam int NEST_W    = 4;
   localparam int CODE_W    = 8;
   localparam int ACC_W     = 32;
   // ************************************************************
   // abort status layout in the accumulator
   // ************************************************************
   localparam int ST_EXPLICIT   = 0;
   localparam int ST_CONFLICT   = 2;
   localparam int ST_CAPACITY   = 3;
   localparam int ST_EVENT      = 4;
   localparam int ST_CODE_LSB   = 24;
   localparam logic [NEST_W-1:0] NEST_MAX = 4'h000F;
   localparam logic [ACC_W-1:0]  ACC_RESET = 32'h0000_0000;

   typedef enum logic [1:0] {TLE_NONE, TLE_ELIDE, TLE_EXPLICIT} tle_mode_e;
   typedef enum {TLE_IDLE, TLE_ACTIVE, TLE_DRAIN} tle_state_e;
endpackage : tle_pkg

// ==== tle_unit.sv ====
// transactional execution tracker for one logical processor
// assumes the core presents one memory or control event per cycle, and that
// the insert line of a set equals its probe line (same address per cycle)
`timescale 1ns/1ns
`default_nettype none
module tle_unit
   import tle_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              elideSupported,
   // core side events
   input  wire logic              coreRead,
   input  wire logic              coreWrite,
   input  wire logic [ADDR_W-1:0] coreAddr,
   input  wire logic [DATA_W-1:0] coreWdata,
   input  wire logic              acquire_elide_hint,
   input  wire logic              release_elide_hint,
   input  wire logic [DATA_W-1:0] lockOldValue,
   input  wire logic              txn_begin_instr,
   input  wire logic [ADDR_W-1:0] fallbackAddr,
   input  wire logic              txn_end_instr,
   input  wire logic              txn_query_instr,
   input  wire logic              txn_explicit_abort_instr,
   input  wire logic [CODE_W-1:0] abortCode,
   input  wire logic              load_tracking_suspend_instr,
   input  wire logic              load_tracking_resume_instr,
   input  wire logic              disruptEvent,
   // peer snoops
   input  wire logic              peerRead,
   input  wire logic              peerWrite,
   input  wire logic [ADDR_W-1:0] peerAddr,
   // outputs
   output logic                   inTxn,
   output logic                   queryResult,
   output logic                   lockReadValid,
   output logic [DATA_W-1:0]      lockReadData,
   output logic                   extWriteValid,
   output logic [ADDR_W-1:0]      extWriteAddr,
   output logic [DATA_W-1:0]      extWriteData,
   output logic                   commitPulse,
   output logic                   abortPulse,
   output logic                   restartValid,
   output logic [ADDR_W-1:0]      restartAddr,
   output logic                   noElideReplay,
   output logic [ACC_W-1:0]       accumulator
);
   // ************************************************************
   // state
   // ************************************************************
   tle_mode_e           mode;
   logic [NEST_W-1:0]   nest;
   logic                loadTrackOff;
   logic [ADDR_W-1:0]   lockAddr;
   logic [DATA_W-1:0]   lockPre;
   logic [DATA_W-1:0]   lockElided;
   logic                lockHeld;
   logic [ADDR_W-1:0]   wbAddr [SET_DEPTH];
   logic [DATA_W-1:0]   wbData [SET_DEPTH];
   logic [SET_IDX_W:0]  wbCount;
   logic [SET_IDX_W:0]  drainIdx;
   logic                draining;

   logic [LINE_W-1:0]   coreLine;
   logic [LINE_W-1:0]   peerLine;
   logic                rdHit, rdPeer, rdFull;
   logic                wrHit, wrPeer, wrFull;
   logic                isLock;
   logic                rdIns, wrIns;
   logic                conflict, capacity, eventAbort, explicitAbort, doAbort;
   logic                startElide, startExplicit, endElide, endExplicit, doCommit;

   assign coreLine = coreAddr[ADDR_W-1:LINE_LSB];
   assign peerLine = peerAddr[ADDR_W-1:LINE_LSB];
   assign isLock   = lockHeld && coreAddr == lockAddr;

   // ************************************************************
   // read and write sets
   // ************************************************************
   // the lock line joins the read set, never the write set
   assign rdIns = inTxn && ((coreRead && !loadTrackOff) || (acquire_elide_hint && isLock)); // R15
   assign wrIns = inTxn && coreWrite && !isLock; // R7 R10

   tle_line_set uReadSet (
      .clk        (clk),
      .rst        (rst),
      .clear      (doAbort || doCommit),
      .insert     (rdIns || (startElide && mode == TLE_NONE)),
      .insertLine (coreLine),
      .probeLine  (coreLine),
      .peerLine   (peerLine),
      .probeHit   (rdHit),
      .peerHit    (rdPeer),
      .full       (rdFull)
   );

   tle_line_set uWriteSet (
      .clk        (clk),
      .rst        (rst),
      .clear      (doAbort || doCommit),
      .insert     (wrIns),
      .insertLine (coreLine),
      .probeLine  (coreLine),
      .peerLine   (peerLine),
      .probeHit   (wrHit),
      .peerHit    (wrPeer),
      .full       (wrFull)
   );

   // ************************************************************
   // abort and commit decisions
   // ************************************************************
   assign conflict = inTxn && ((peerRead && wrPeer) || (peerWrite && (rdPeer || wrPeer))); // R2
   // capacity is judged on the write buffer too since it is the same depth
   assign capacity = inTxn && ((rdIns && rdFull && !rdHit) || (wrIns && wbCount[SET_IDX_W])
                     || (acquire_elide_hint && nest == NEST_MAX)); // R6
   assign eventAbort    = inTxn && disruptEvent; // R6
   assign explicitAbort = inTxn && txn_explicit_abort_instr; // R14
   assign doAbort       = conflict || capacity || eventAbort || explicitAbort; // R3

   // hints degrade to legacy prefixes when elision is absent
   assign startElide    = elideSupported && acquire_elide_hint && !doAbort && !draining; // R12
   assign startExplicit = txn_begin_instr && mode != TLE_ELIDE && !draining;
   assign endElide      = mode == TLE_ELIDE && release_elide_hint && nest == 4'h0001
                          && isLock && coreWdata == lockPre; // R10
   assign endExplicit   = mode == TLE_EXPLICIT && txn_end_instr && nest == 4'h0001;
   assign doCommit      = (endElide || endExplicit) && !doAbort; // R18

   // ************************************************************
   // mode, nesting and in-transaction flag
   // ************************************************************
   always_ff @(posedge clk) begin
      if (rst || doAbort || doCommit) begin
         mode  <= TLE_NONE;
         nest  <= '0;
         inTxn <= 1'b0; // R19
      end else if (startElide && mode != TLE_EXPLICIT) begin
         mode  <= TLE_ELIDE;
         nest  <= nest + 1'b1; // R18
         inTxn <= 1'b1;
      end else if (startExplicit) begin
         mode  <= TLE_EXPLICIT;
         nest  <= nest + 1'b1;
         inTxn <= 1'b1;
      end else if ((mode == TLE_ELIDE && release_elide_hint)
                   || (mode == TLE_EXPLICIT && txn_end_instr)) begin
         nest <= nest - 1'b1; // R18
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         queryResult <= 1'b0;
      end else begin
         queryResult <= txn_query_instr ? inTxn : queryResult; // R14 R19
      end
   end

   always_ff @(posedge clk) begin
      if (rst || doAbort || doCommit) begin
         loadTrackOff <= 1'b0;
      end else if (inTxn && load_tracking_suspend_instr) begin
         loadTrackOff <= 1'b1; // R15
      end else if (load_tracking_resume_instr) begin
         loadTrackOff <= 1'b0; // R15
      end
   end

   // ************************************************************
   // elided lock
   // ************************************************************
   always_ff @(posedge clk) begin
      if (rst || doAbort || doCommit) begin
         lockHeld   <= 1'b0;
         lockAddr   <= '0;
         lockPre    <= '0;
         lockElided <= '0;
      end else if (startElide && !lockHeld && mode == TLE_NONE) begin
         lockHeld   <= 1'b1; // R7
         lockAddr   <= coreAddr;
         lockPre    <= lockOldValue;
         lockElided <= coreWdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lockReadValid <= 1'b0;
         lockReadData  <= '0;
      end else begin
         lockReadValid <= coreRead && isLock; // R9
         lockReadData  <= lockElided; // R9
      end
   end

   // ************************************************************
   // write buffer and atomic drain
   // ************************************************************
   always_ff @(posedge clk) begin
      if (rst || doAbort) begin
         wbCount <= '0; // R5
      end else if (draining && drainIdx + 1'b1 >= wbCount) begin
         wbCount <= '0;
      end else if (wrIns && !wbCount[SET_IDX_W]) begin
         wbAddr[wbCount[SET_IDX_W-1:0]] <= coreAddr; // R4
         wbData[wbCount[SET_IDX_W-1:0]] <= coreWdata;
         wbCount <= wbCount + 1'b1;
      end
   end

   // stores leave only after commit; a drain blocks new regions until done
   always_ff @(posedge clk) begin
      if (rst) begin
         draining <= 1'b0;
         drainIdx <= '0;
      end else if (doCommit && wbCount != 0) begin
         draining <= 1'b1; // R4
         drainIdx <= '0;
      end else if (draining) begin
         draining <= drainIdx + 1'b1 < wbCount;
         drainIdx <= drainIdx + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         extWriteValid <= 1'b0;
         extWriteAddr  <= '0;
         extWriteData  <= '0;
      end else if (draining) begin
         extWriteValid <= 1'b1; // R4
         extWriteAddr  <= wbAddr[drainIdx[SET_IDX_W-1:0]];
         extWriteData  <= wbData[drainIdx[SET_IDX_W-1:0]];
      end else begin
         // outside a region writes pass, except during a drain or in a region's opening cycle; lock writes while eliding never do
         extWriteValid <= coreWrite && !inTxn && !startElide && !startExplicit; // R8
         extWriteAddr  <= coreAddr;
         extWriteData  <= coreWdata;
      end
   end

   // ************************************************************
   // abort status, restart and fallback
   // ************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         restartAddr <= '0;
      end else if (startExplicit && mode == TLE_NONE) begin
         restartAddr <= fallbackAddr; // R16
      end else if (startElide && mode == TLE_NONE) begin
         restartAddr <= coreAddr;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         commitPulse   <= 1'b0;
         abortPulse    <= 1'b0;
         restartValid  <= 1'b0;
         noElideReplay <= 1'b0;
         accumulator   <= ACC_RESET;
      end else begin
         commitPulse  <= doCommit;
         abortPulse   <= doAbort; // R5
         restartValid <= doAbort; // R16
         noElideReplay <= doAbort && mode == TLE_ELIDE; // R11
         if (doAbort && mode == TLE_EXPLICIT) begin
            accumulator <= '0;
            accumulator[ST_EXPLICIT] <= explicitAbort;
            accumulator[ST_CONFLICT] <= conflict;
            accumulator[ST_CAPACITY] <= capacity;
            accumulator[ST_EVENT]    <= eventAbort;
            if (explicitAbort) begin
               accumulator[ST_CODE_LSB +: CODE_W] <= abortCode; // R17
            end
         end
      end
   end
endmodule : tle_unit
`default_nettype wire

// ==== tle_unit_bench.sv ====
// bench for the lock elision unit against one peer processor model
// assumes tle_pkg, tle_unit and tle_peer are compiled before it
`timescale 1ns/1ns
`default_nettype none
module tle_unit_bench
   import tle_pkg::*;
;
   localparam logic [31:0] A = 32'h0000_1000, B = 32'h0000_2000, L = 32'h0000_3000;
   localparam logic [31:0] M = 32'h0000_4000, F = 32'h0000_8000, Z = 32'h0000_0000;
   localparam logic [12:0] RD = 13'h0001, WR = 13'h0002, ACQ = 13'h0004, REL = 13'h0008;
   localparam logic [12:0] BEG = 13'h0010, ENDI = 13'h0020, QRY = 13'h0040, XAB = 13'h0080;
   localparam logic [12:0] SUS = 13'h0100, RES = 13'h0200, DIS = 13'h0400, PR = 13'h0800;
   localparam logic [12:0] PW = 13'h1800, IDLE = 13'h0000;
   logic        clk, rst, elOk, rd, wr, acq, rel, beg, endI, qry, xab, sus, res, dis, pGo;
   logic        pWr, pRd, pWrO, inTxn, qRes, lrV, ewV, cmt, abt, rsV, noEl;
   logic [31:0] addr, wd, lockOld, fb, pA, pAd, lrD, ewA, ewD, rsA, acc;
   logic [7:0]  code, nSeen, n0;
   int          num_errors, n_compared;
   tle_unit i_tle_unit (.clk(clk), .rst(rst), .elideSupported(elOk), .coreRead(rd),
      .coreWrite(wr), .coreAddr(addr), .coreWdata(wd), .acquire_elide_hint(acq),
      .release_elide_hint(rel), .lockOldValue(lockOld), .txn_begin_instr(beg),
      .fallbackAddr(fb), .txn_end_instr(endI), .txn_query_instr(qry),
      .txn_explicit_abort_instr(xab), .abortCode(code), .load_tracking_suspend_instr(sus),
      .load_tracking_resume_instr(res), .disruptEvent(dis), .peerRead(pRd),
      .peerWrite(pWrO), .peerAddr(pAd), .inTxn(inTxn), .queryResult(qRes),
      .lockReadValid(lrV), .lockReadData(lrD), .extWriteValid(ewV), .extWriteAddr(ewA),
      .extWriteData(ewD), .commitPulse(cmt), .abortPulse(abt), .restartValid(rsV),
      .restartAddr(rsA), .noElideReplay(noEl), .accumulator(acc));
   tle_peer i_tle_peer (.clk(clk), .rst(rst), .go(pGo), .isWrite(pWr), .cmdAddr(pA),
      .extWriteValid(ewV), .peerRead(pRd), .peerWrite(pWrO), .peerAddr(pAd), .nSeen(nSeen));
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   // ********
   // shared tasks
   // ********
   // every event sets all strobes at once, so none is assigned twice per step
   task ev(input logic [12:0] p, input logic [31:0] a, d);
      {pWr, pGo, dis, res, sus, xab, qry, endI, beg, rel, acq, wr, rd} = p;
      {addr, pA, fb, wd} = {a, a, a, d};
      code = d[7:0];
      @(negedge clk);
   endtask : ev
   task chk(input logic [31:0] g, e);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task wt(input logic c);
      for (int i = 0; i < 20; i++) begin
         if ((c ? cmt : abt) === 1'h1) return;
         ev(IDLE, Z, Z);
      end
      chk(32'h0000_0000, 32'h0000_0001);
      results();
   endtask : wt
   task results;
      if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results
   // ********
   // scenarios
   // ********
   task s_commit;
      n0 = nSeen;
      ev(BEG, F, Z);
      ev(WR, A, 32'h1111_1111);
      ev(WR, B, 32'h2222_2222);
      ev(RD, L, Z);
      chk(nSeen, n0);
      ev(ENDI, Z, Z);
      wt(1'h1);
      repeat (4) ev(IDLE, Z, Z);
      chk(nSeen, n0 + 8'h02);
   endtask : s_commit
   // same-line offsets: conflicts are judged per line, not per word
   task s_conflict;
      for (int k = 0; k < 3; k++) begin
         n0 = nSeen;
         ev(BEG, F + k * 64, Z);
         ev(k == 0 ? WR : RD, k == 0 ? A : B, Z);
         ev(k == 1 ? PW : PR, (k == 0 ? A : B) + 32'h0000_0004, Z);
         if (k < 2) begin
            wt(1'h0);
            chk(rsV, 1'h1);
            chk(rsA, F + k * 64);
            chk(acc[ST_CONFLICT], 1'h1);
            repeat (3) ev(IDLE, Z, Z);
            chk(nSeen, n0);
         end else begin
            ev(ENDI, Z, Z);
            wt(1'h1);
         end
         repeat (2) ev(IDLE, Z, Z);
      end
   endtask : s_conflict
   task s_explicit;
      ev(BEG, F, Z);
      ev(QRY, Z, Z);
      chk(qRes, 1'h1);
      ev(WR, A, Z);
      ev(XAB, Z, 32'h0000_00A5);
      wt(1'h0);
      chk(acc[31:24], 8'hA5);
      chk(acc[ST_EXPLICIT], 1'h1);
      ev(QRY, Z, Z);
      chk(qRes, 1'h0);
      ev(IDLE, Z, Z);
   endtask : s_explicit
   task s_elide;
      n0 = nSeen;
      lockOld = 32'h0000_0002;
      ev(ACQ | WR, L, 32'h0000_0001);
      chk(inTxn, 1'h1);
      ev(ACQ | WR, M, 32'h0000_0001);
      ev(PR, L, Z);
      chk(abt, 1'h0);
      ev(RD, L, Z);
      chk(lrV, 1'h1);
      chk(lrD, 32'h0000_0001);
      ev(REL | WR, M, Z);
      chk(cmt, 1'h0);
      ev(REL | WR, L, 32'h0000_0002);
      wt(1'h1);
      // only the second, non-elided lock reaches the fabric, after commit
      ev(IDLE, Z, Z);
      chk(ewA, M);
      chk(ewD, 32'h0000_0001);
      repeat (2) ev(IDLE, Z, Z);
      chk(nSeen, n0 + 8'h02);
   endtask : s_elide
   task s_replay;
      n0 = nSeen;
      ev(ACQ | WR, L, 32'h0000_0001);
      ev(DIS, Z, Z);
      wt(1'h0);
      chk(noEl, 1'h1);
      chk(rsA, L);
      ev(WR, L, 32'h0000_0001);
      ev(WR, L, Z);
      repeat (2) ev(IDLE, Z, Z);
      chk(nSeen, n0 + 8'h02);
   endtask : s_replay
   task s_legacy;
      elOk = 1'h0;
      n0 = nSeen;
      ev(ACQ | WR, L, 32'h0000_0001);
      chk(inTxn, 1'h0);
      ev(REL | WR, L, Z);
      repeat (2) ev(IDLE, Z, Z);
      chk(nSeen, n0 + 8'h02);
      elOk = 1'h1;
   endtask : s_legacy
   task s_suspend;
      ev(BEG, F, Z);
      ev(SUS, Z, Z);
      ev(RD, B, Z);
      ev(RES, Z, Z);
      ev(PW, B, Z);
      chk(abt, 1'h0);
      ev(ENDI, Z, Z);
      wt(1'h1);
      ev(IDLE, Z, Z);
   endtask : s_suspend
   initial begin
      {rd, wr, acq, rel, beg, endI, qry, xab, sus, res, dis, pGo, pWr} = '0;
      {addr, wd, fb, pA, code, lockOld} = '0;
      elOk = 1'h1;
      rst = 1'h1;
      repeat (10) @(negedge clk);
      rst = 1'h0;
      ev(IDLE, Z, Z);
      s_commit();
      s_conflict();
      s_explicit();
      s_elide();
      s_replay();
      s_legacy();
      s_suspend();
      results();
   end
endmodule : tle_unit_bench
`default_nettype wire

// ==== tle_unit_sva.sv ====
// assertion checker bound to every lock elision unit instance
// assumes the unit's single clock and synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module tle_unit_sva
   import tle_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic elideSupported,
   input wire logic acquire_elide_hint,
   input wire logic release_elide_hint,
   input wire logic txn_begin_instr,
   input wire logic txn_end_instr,
   input wire logic txn_query_instr,
   input wire logic txn_explicit_abort_instr,
   input wire logic disruptEvent,
   input wire logic inTxn,
   input wire logic queryResult,
   input wire logic extWriteValid,
   input wire logic commitPulse,
   input wire logic abortPulse,
   input wire logic restartValid,
   input wire logic noElideReplay
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_enter;
      $rose(inTxn) |-> $past(txn_begin_instr | (acquire_elide_hint & elideSupported));
   endproperty
   a_enter: assert property (p_enter) else $error("region opened without cause");
   // a write launched in the opening cycle is not part of the region
   property p_hold; inTxn && $past(inTxn) |-> !extWriteValid; endproperty
   a_hold: assert property (p_hold) else $error("write seen inside region");
   property p_commit;
      commitPulse |-> !inTxn && $past(inTxn && (txn_end_instr | release_elide_hint));
   endproperty
   a_commit: assert property (p_commit) else $error("commit without closer");
   property p_abort; abortPulse |-> !inTxn && !commitPulse && (restartValid | noElideReplay);
   endproperty
   a_abort: assert property (p_abort) else $error("abort without restart");
   property p_query; txn_query_instr |=> queryResult == $past(inTxn); endproperty
   a_query: assert property (p_query) else $error("query result wrong");
   property p_txn_explicit_abort_instr; inTxn && txn_explicit_abort_instr |=> abortPulse && !inTxn; endproperty
   a_txn_explicit_abort_instr: assert property (p_txn_explicit_abort_instr) else $error("explicit abort ignored");
   property p_event; inTxn && disruptEvent |=> abortPulse; endproperty
   a_event: assert property (p_event) else $error("event did not abort");
   property p_legacy;
      !elideSupported && acquire_elide_hint && !txn_begin_instr && !inTxn |=> !inTxn;
   endproperty
   a_legacy: assert property (p_legacy) else $error("hint elided when unsupported");
endmodule : tle_unit_sva
bind tle_unit tle_unit_sva i_tle_unit_sva (.clk(clk), .rst(rst),
   .elideSupported(elideSupported), .acquire_elide_hint(acquire_elide_hint),
   .release_elide_hint(release_elide_hint), .txn_begin_instr(txn_begin_instr),
   .txn_end_instr(txn_end_instr), .txn_query_instr(txn_query_instr),
   .txn_explicit_abort_instr(txn_explicit_abort_instr), .disruptEvent(disruptEvent),
   .inTxn(inTxn), .queryResult(queryResult), .extWriteValid(extWriteValid),
   .commitPulse(commitPulse), .abortPulse(abortPulse), .restartValid(restartValid),
   .noElideReplay(noElideReplay));
`default_nettype wire
